// File: logic/dxm_cmd_delay.sv
// module: holds read and write commands for the additive latency
module dxm_cmd_delay
   import dxm_pkg::*;
(
   input wire logic core_clk, // device clock
   input wire logic rst_b, // async reset, active low
   dxm_cmd_if.dly cmd // commands in, delayed commands out
);
   logic [1:0] pipe_ff [AL_MAX]; // {read, write} one stage per clock
   logic [1:0] tap; // stage picked by the latency

   // shift the commands one stage each clock
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < AL_MAX; i++) begin
            pipe_ff[i] <= 2'h0;
         end
      end else begin
         pipe_ff[0] <= {cmd.rd_in, cmd.wr_in};
         for (int i = 1; i < AL_MAX; i++) begin
            pipe_ff[i] <= pipe_ff[i-1];
         end
      end
   end

   // zero latency passes straight; a reserved code acts as zero
   always_comb begin
      if (cmd.al == 3'h0 || cmd.al > AL_MAX_CODE) begin
         tap = {cmd.rd_in, cmd.wr_in};
      end else begin
         tap = pipe_ff[cmd.al - 3'h1];
      end
   end

   assign cmd.rd_out = tap[1];
   assign cmd.wr_out = tap[0];
endmodule // dxm_cmd_delay

// File: logic/dxm_cmd_if.sv
// interface: column commands into and out of the additive latency delay line
interface dxm_cmd_if;
   logic rd_in; // read command seen on the pins
   logic wr_in; // write command seen on the pins
   logic [2:0] al; // current additive latency
   logic rd_out; // read command due internally now
   logic wr_out; // write command due internally now
   modport src (output rd_in, output wr_in, output al, input rd_out, input wr_out);
   modport dly (input rd_in, input wr_in, input al, output rd_out, output wr_out);
endinterface

// File: logic/dxm_ext_mode.sv
// module: extended mode registers and the settings they drive
//
// Contract
// - loop enable follows written loop disable bit
// - self refresh stops loop; exit restarts, resets
// - drive strength bit selects full or reduced
// - strobe disable bit gates complementary strobe
// - complementary read strobe needs both enable bits
// - byte-wide read strobe mirrors strobe on reads
// - output disable bit turns off all outputs
// - select bits choose termination off/50/75/150
// - termination pin switches only in allowed states
// - additive latency field gives zero to six; code 7 still reaches the latency outputs
// - column commands held for additive latency
// - read is additive plus column; write one less
// - registers hold contents until rewritten
// - bank one-low selects first extended register
// - bank low-one selects second extended register
// - both bank bits high select third register
module dxm_ext_mode
   import dxm_pkg::*;
(
   input wire logic core_clk, // device clock, 40 MHz
   input wire logic rst_b, // async reset, active low
   input wire logic cs_b, // chip select, active low
   input wire logic ras_b, // row strobe, active low
   input wire logic cas_b, // column strobe, active low
   input wire logic we_b, // write enable, active low
   input wire logic [2:0] bank_addr, // bank address, bit 2 is E16
   input wire logic [15:0] addr, // address bus, mode bits E0..E15
   input wire logic termination_control, // asynchronous termination pin
   input wire logic self_refresh, // device is in self refresh
   input wire logic bank_open, // some bank is active
   input wire logic power_down, // device in a power-down state
   input wire logic [2:0] column_latency, // from the base mode register
   output logic loop_enable_ff, // delay-locked loop running
   output logic loop_reset_ff, // one-cycle loop reset pulse
   output logic drive_reduced_ff, // reduced output drive selected
   output logic dqs_comp_enable_ff, // complementary strobe driven
   output logic read_strobe_enable_ff, // read strobe driven on reads
   output logic read_strobe_comp_enable_ff, // complementary read strobe
   output logic data_out_enable_ff, // data and strobe outputs enabled
   output logic [1:0] term_code_ff, // selected termination value
   output logic term_active_ff, // termination switched on now
   output logic [2:0] calib_code_ff, // driver calibration bits
   output logic [2:0] additive_latency_ff, // additive latency in clocks
   output logic [3:0] read_latency_ff, // read latency in clocks
   output logic [3:0] write_latency_ff, // write latency in clocks
   output logic fast_refresh_ff, // faster refresh rate selected
   output logic [16:0] extended_mode_two_ff, // second extended register
   output logic [16:0] extended_mode_three_ff, // third extended register
   output logic int_read_ff, // read issued internally
   output logic int_write_ff // write issued internally
);
   logic [16:0] extended_mode_one_ff; // first extended register
   logic [16:0] nxt_extended_mode_one; // its next value
   logic [16:0] mode_word; // value presented by the pins
   logic cmd_sel; // chip selected
   logic load_mode_command; // load-mode seen this cycle
   logic rd_cmd; // read seen this cycle
   logic wr_cmd; // write seen this cycle
   logic wr_one; // load into the first register
   logic wr_two; // load into the second register
   logic wr_three; // load into the third register
   logic term_pin_ff; // synchronised termination pin
   logic term_allowed; // state lets the pin act
   logic [1:0] nxt_term_code; // termination code of the next word
   logic [2:0] nxt_al; // additive latency of the next word
   dxm_loop_type loop_state_ff; // loop control state
   dxm_loop_type nxt_loop_state; // its next value
   dxm_cmd_if cmd_bus (); // link to the delay line

   // command decode straight from the pins, same clock as the controller
   assign cmd_sel = !cs_b;
   assign load_mode_command = cmd_sel && ({ras_b, cas_b, we_b} == CMD_LOAD_MODE);
   assign rd_cmd = cmd_sel && ({ras_b, cas_b, we_b} == CMD_READ);
   assign wr_cmd = cmd_sel && ({ras_b, cas_b, we_b} == CMD_WRITE);
   // bank bits 1..0 pick the target; bank bit 2 lands in E16
   assign mode_word = {bank_addr[2], addr};
   assign wr_one = load_mode_command && (bank_addr[1:0] == BANK_SEL_ONE);
   assign wr_two = load_mode_command && (bank_addr[1:0] == BANK_SEL_TWO);
   assign wr_three = load_mode_command && (bank_addr[1:0] == BANK_SEL_THREE);

   // value of the first register after this edge
   always_comb begin
      if (wr_one) begin
         nxt_extended_mode_one = mode_word;
      end else begin
         nxt_extended_mode_one = extended_mode_one_ff;
      end
   end

   // fields decoded from the next word so settings apply right after the load
   assign nxt_term_code = {nxt_extended_mode_one[TERMINATION_SELECT_HIGH],
                           nxt_extended_mode_one[TERMINATION_SELECT_LOW]};
   assign nxt_al = nxt_extended_mode_one[ADDITIVE_LATENCY_MSB:ADDITIVE_LATENCY_LSB];

   // first extended register store
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         extended_mode_one_ff <= MODE_RESET;
      end else begin
         extended_mode_one_ff <= nxt_extended_mode_one;
      end
   end

   // second and third extended registers; only a matching load changes them
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         extended_mode_two_ff <= MODE_RESET;
         extended_mode_three_ff <= MODE_RESET;
         fast_refresh_ff <= 1'b0;
      end else begin
         if (wr_two) begin
            extended_mode_two_ff <= mode_word;
            fast_refresh_ff <= mode_word[FAST_REFRESH_BIT];
         end
         if (wr_three) begin
            extended_mode_three_ff <= mode_word;
         end
      end
   end

   // loop state: write of the disable bit, self refresh entry and exit
   always_comb begin
      nxt_loop_state = loop_state_ff;
      case (loop_state_ff)
         LOOP_OFF: begin
            if (self_refresh) begin
               nxt_loop_state = LOOP_SELF_REFRESH;
            end else if (!nxt_extended_mode_one[LOOP_DISABLE_BIT]) begin
               nxt_loop_state = LOOP_RUN;
            end
         end
         LOOP_RUN: begin
            if (self_refresh) begin
               nxt_loop_state = LOOP_SELF_REFRESH;
            end else if (nxt_extended_mode_one[LOOP_DISABLE_BIT]) begin
               nxt_loop_state = LOOP_OFF;
            end
         end
         LOOP_SELF_REFRESH: begin
            if (!self_refresh) begin
               nxt_loop_state = LOOP_RUN;
            end
         end
         default: begin
            nxt_loop_state = LOOP_OFF;
         end
      endcase
   end

   // loop state register and its outputs
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         loop_state_ff <= LOOP_RUN;
         loop_enable_ff <= 1'b1;
         loop_reset_ff <= 1'b0;
      end else begin
         loop_state_ff <= nxt_loop_state;
         loop_enable_ff <= (nxt_loop_state == LOOP_RUN);
         // leaving self refresh restarts the loop with a reset pulse
         loop_reset_ff <= (loop_state_ff == LOOP_SELF_REFRESH) && !self_refresh;
      end
   end

   // output buffer settings from the next first-register value
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         drive_reduced_ff <= 1'b0;
         dqs_comp_enable_ff <= 1'b0;
         read_strobe_enable_ff <= 1'b0;
         read_strobe_comp_enable_ff <= 1'b0;
         data_out_enable_ff <= 1'b0;
         calib_code_ff <= 3'h0;
      end else begin
         drive_reduced_ff <= nxt_extended_mode_one[DRIVE_STRENGTH_BIT];
         // output disable overrides every strobe and data enable
         data_out_enable_ff <= !nxt_extended_mode_one[OUTPUT_DISABLE_BIT];
         dqs_comp_enable_ff <= !nxt_extended_mode_one[COMPLEMENT_STROBE_DISABLE_BIT]
                               && !nxt_extended_mode_one[OUTPUT_DISABLE_BIT];
         // read strobe only exists on the byte-wide part; writes ignore it
         read_strobe_enable_ff <= BYTE_WIDE_CFG
                                  && nxt_extended_mode_one[READ_STROBE_ENABLE_BIT]
                                  && !nxt_extended_mode_one[OUTPUT_DISABLE_BIT];
         read_strobe_comp_enable_ff <= BYTE_WIDE_CFG
                                  && nxt_extended_mode_one[READ_STROBE_ENABLE_BIT]
                                  && !nxt_extended_mode_one[COMPLEMENT_STROBE_DISABLE_BIT]
                                  && !nxt_extended_mode_one[OUTPUT_DISABLE_BIT];
         calib_code_ff <= nxt_extended_mode_one[CALIB_MSB:CALIB_LSB];
      end
   end

   // termination pin passes the synchroniser before it acts
   dxm_sync3 u_term_sync (
      .core_clk (core_clk),
      .rst_b (rst_b),
      .pin_in (termination_control),
      .level_ff (term_pin_ff)
   );

   // the pin acts in active, active power-down and precharge power-down
   assign term_allowed = !self_refresh && (bank_open || power_down);

   // termination selection and switching
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         term_code_ff <= TERM_OFF;
         term_active_ff <= 1'b0;
      end else begin
         term_code_ff <= nxt_term_code;
         term_active_ff <= (nxt_term_code != TERM_OFF) && term_pin_ff
                           && term_allowed;
      end
   end

   // latencies; column latency comes from the base register
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         additive_latency_ff <= 3'h0;
         read_latency_ff <= 4'h0;
         write_latency_ff <= 4'h0;
      end else begin
         additive_latency_ff <= nxt_al;
         read_latency_ff <= {1'b0, nxt_al} + {1'b0, column_latency};
         write_latency_ff <= {1'b0, nxt_al} + {1'b0, column_latency} - 4'h1;
      end
   end

   // column commands go through the delay line at the stored latency
   assign cmd_bus.rd_in = rd_cmd;
   assign cmd_bus.wr_in = wr_cmd;
   assign cmd_bus.al = extended_mode_one_ff[ADDITIVE_LATENCY_MSB:ADDITIVE_LATENCY_LSB];

   dxm_cmd_delay u_delay (
      .core_clk (core_clk),
      .rst_b (rst_b),
      .cmd (cmd_bus.dly)
   );

   // internal command strobes, registered
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         int_read_ff <= 1'b0;
         int_write_ff <= 1'b0;
      end else begin
         int_read_ff <= cmd_bus.rd_out;
         int_write_ff <= cmd_bus.wr_out;
      end
   end

   // checks on the settings and timing
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   loop_bit_follow_a: assert property (
      (wr_one && !self_refresh && loop_state_ff != LOOP_SELF_REFRESH)
      |=> loop_enable_ff == !$past(addr[LOOP_DISABLE_BIT]))
      else $error("loop enable does not follow written bit");

   loop_sr_stop_a: assert property (
      self_refresh |=> !loop_enable_ff)
      else $error("loop still enabled in self refresh");

   loop_sr_exit_a: assert property (
      (loop_state_ff == LOOP_SELF_REFRESH && !self_refresh)
      |=> loop_reset_ff && loop_enable_ff ##1 !loop_reset_ff)
      else $error("loop not restarted with one reset pulse");

   drive_sel_a: assert property (
      wr_one |=> drive_reduced_ff == $past(addr[DRIVE_STRENGTH_BIT]))
      else $error("drive strength does not follow written bit");

   comp_strobe_a: assert property (
      read_strobe_comp_enable_ff |-> dqs_comp_enable_ff && read_strobe_enable_ff)
      else $error("complementary read strobe enabled alone");

   strobe_gate_a: assert property (
      wr_one && addr[COMPLEMENT_STROBE_DISABLE_BIT] |=> !dqs_comp_enable_ff)
      else $error("complementary strobe left enabled");

   out_disable_a: assert property (
      wr_one && addr[OUTPUT_DISABLE_BIT] |=> !data_out_enable_ff && !dqs_comp_enable_ff
      && !read_strobe_enable_ff && !read_strobe_comp_enable_ff)
      else $error("outputs not disabled");

   term_gate_a: assert property (
      term_active_ff |-> term_code_ff != TERM_OFF && $past(term_allowed))
      else $error("termination on while not allowed");

   latency_sum_a: assert property (
      $past(rst_b) |-> read_latency_ff == $past(nxt_al) + $past(column_latency)
      && write_latency_ff == read_latency_ff - 4'h1)
      else $error("read or write latency wrong");

   al_hold_a: assert property (
      (rd_cmd && !wr_one && cmd_bus.al == 3'h3) ##1 (!wr_one)[*2]
      |=> ##1 int_read_ff)
      else $error("read not issued after three clocks");

   reg_hold_a: assert property (
      !wr_two |=> $stable(extended_mode_two_ff))
      else $error("second register changed without a load");

   bank_select_a: assert property (
      wr_one |=> extended_mode_one_ff == $past(mode_word) && $stable(extended_mode_three_ff))
      else $error("first register load misrouted");
endmodule // dxm_ext_mode

// File: logic/dxm_pkg.sv
// package: field layout, command codes and constants of the extended mode registers
package dxm_pkg;
   // width of one extended mode word, E0 to E16
   localparam int MODE_W = 17;
   localparam int ADDR_W = 16;
   localparam int BANK_W = 3;
   // field positions inside the first extended register
   localparam int LOOP_DISABLE_BIT = 0;
   localparam int DRIVE_STRENGTH_BIT = 1;
   localparam int TERMINATION_SELECT_LOW = 2;
   localparam int ADDITIVE_LATENCY_LSB = 3;
   localparam int ADDITIVE_LATENCY_MSB = 5;
   localparam int TERMINATION_SELECT_HIGH = 6;
   localparam int CALIB_LSB = 7;
   localparam int CALIB_MSB = 9;
   localparam int COMPLEMENT_STROBE_DISABLE_BIT = 10;
   localparam int READ_STROBE_ENABLE_BIT = 11;
   localparam int OUTPUT_DISABLE_BIT = 12;
   localparam int TOP_RESERVED_BIT = 16;
   // field position inside the second extended register
   localparam int FAST_REFRESH_BIT = 7;
   // reset value of every extended register
   localparam logic [16:0] MODE_RESET = 17'h00000;
   // bank address codes selecting the extended registers
   localparam logic [1:0] BANK_SEL_ONE = 2'h1;
   localparam logic [1:0] BANK_SEL_TWO = 2'h2;
   localparam logic [1:0] BANK_SEL_THREE = 2'h3;
   // {ras_b, cas_b, we_b} codes with chip select low
   localparam logic [2:0] CMD_LOAD_MODE = 3'h0;
   localparam logic [2:0] CMD_WRITE = 3'h4;
   localparam int CMD_READ_I = 5;
   localparam logic [2:0] CMD_READ = 3'h5;
   // additive latency range in clocks
   localparam int AL_MAX = 6;
   localparam logic [2:0] AL_MAX_CODE = 3'h6;
   localparam int LAT_W = 4;
   // termination codes as {high, low} select bits
   localparam logic [1:0] TERM_OFF = 2'h0;
   localparam logic [1:0] TERM_75 = 2'h1;
   localparam logic [1:0] TERM_150 = 2'h2;
   localparam logic [1:0] TERM_50 = 2'h3;
   // read strobe exists only on the byte-wide part
   localparam logic BYTE_WIDE_CFG = 1'b1;
   // delay-locked loop control states, one-hot
   typedef enum logic [2:0] {
      LOOP_OFF = 3'h1,
      LOOP_RUN = 3'h2,
      LOOP_SELF_REFRESH = 3'h4
   } dxm_loop_type;
endpackage

// File: logic/dxm_sync3.sv
// module: three-flop synchroniser that accepts a change once two stages agree
module dxm_sync3 (
   input wire logic core_clk, // device clock
   input wire logic rst_b, // async reset, active low
   input wire logic pin_in, // asynchronous pin level
   output logic level_ff // filtered synchronous level
);
   logic s1_ff; // first stage, read only by s2_ff
   logic s2_ff; // second stage
   logic s3_ff; // third stage

   // synchroniser chain
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
      end else begin
         s1_ff <= pin_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // take the new level only when stages two and three agree
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         level_ff <= 1'b0;
      end else if (s2_ff == s3_ff) begin
         level_ff <= s3_ff;
      end
   end
endmodule // dxm_sync3

// File: tb/dxm_ctrl_model.sv
// partner model: controller that turns bench requests into command and termination pins
module dxm_ctrl_model
   import dxm_pkg::*;
(
   input wire logic core_clk, // device clock
   input wire logic rst_b, // async reset, active low
   input wire logic [1:0] req_op, // 0 none, 1 load, 2 read, 3 write
   input wire logic [1:0] req_bank, // register select
   input wire logic [15:0] req_word, // mode word
   input wire logic req_term, // termination wanted
   input wire logic req_sr, // self refresh wanted
   output logic cs_b, // chip select, active low
   output logic ras_b, // row strobe, active low
   output logic cas_b, // column strobe, active low
   output logic we_b, // write enable, active low
   output logic [2:0] bank_addr, // bank address
   output logic [15:0] addr, // address bus
   output logic termination_control, // termination pin
   output logic self_refresh // self refresh state
);
   logic [3:0] guard_ff; // clocks left before termination may rise
   // one command cycle per request; idle bus inverts the address each clock, so the last word returns every second idle cycle
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         {cs_b, ras_b, cas_b, we_b} <= 4'hF;
         bank_addr <= 3'h0;
         addr <= 16'h0000;
      end else if (req_op != 2'h0) begin
         cs_b <= 1'b0;
         case (req_op)
            2'h1: {ras_b, cas_b, we_b} <= CMD_LOAD_MODE;
            2'h2: {ras_b, cas_b, we_b} <= CMD_READ;
            default: {ras_b, cas_b, we_b} <= CMD_WRITE;
         endcase
         bank_addr <= {1'b0, req_bank};
         addr <= req_word & 16'h1FFF;
      end else begin
         {cs_b, ras_b, cas_b, we_b} <= 4'hF; // deselect
         addr <= ~addr; // released bus flips
      end
   end
   // guard after a load that switches termination on
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         guard_ff <= 4'h0;
      end else if (req_op == 2'h1 && req_bank == 2'h1 && {req_word[6], req_word[2]} != 2'h0) begin
         guard_ff <= 4'h9;
      end else if (guard_ff != 4'h0) begin
         guard_ff <= guard_ff - 4'h1;
      end
   end
   // pin drops a cycle before self refresh is entered
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         termination_control <= 1'b0;
         self_refresh <= 1'b0;
      end else begin
         termination_control <= req_term && !req_sr && guard_ff == 4'h0;
         self_refresh <= req_sr && !termination_control;
      end
   end
endmodule // dxm_ctrl_model

// File: tb/dxm_ext_mode_tb.sv
// testbench: mode loads, column delay, termination and self refresh of the extended mode block
`define CHK(nm, exp, got) begin \
   check_count++; \
   if ((got) !== (exp)) begin \
      miscompares++; \
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got); \
   end \
end
module dxm_ext_mode_tb import dxm_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [3:0] CL = 4'h3; // column latency used throughout
   // first register words: loop and drive bits, strobe and output-disable mixes, termination codes, calibration
   localparam logic [15:0] WORDS [10] = '{16'h0001, 16'h0002, 16'h0400, 16'h0800, 16'h0C00,
      16'h1800, 16'h0004, 16'h0040, 16'h0044, 16'h0380};
   logic core_clk, rst_b, req_term, req_sr, bank_open, power_down; // bench drives
   logic [1:0] req_op, req_bank; // request to the controller model
   logic [15:0] req_word, addr; // mode word, address bus
   logic [2:0] column_latency, bank_addr, additive_latency_ff, calib_code_ff; // buses
   logic cs_b, ras_b, cas_b, we_b, termination_control, self_refresh; // pins
   logic loop_enable_ff, loop_reset_ff, drive_reduced_ff, dqs_comp_enable_ff; // settings
   logic read_strobe_enable_ff, read_strobe_comp_enable_ff, data_out_enable_ff; // strobes
   logic term_active_ff, fast_refresh_ff, int_read_ff, int_write_ff; // status
   logic [1:0] term_code_ff; // termination select
   logic [3:0] read_latency_ff, write_latency_ff; // latencies
   logic [16:0] extended_mode_two_ff, extended_mode_three_ff; // register contents
   int miscompares, check_count; // verdict counters
   dxm_ctrl_model ctrl_u (.core_clk, .rst_b, .req_op, .req_bank, .req_word, .req_term,
      .req_sr, .cs_b, .ras_b, .cas_b, .we_b, .bank_addr, .addr, .termination_control,
      .self_refresh);
   dxm_ext_mode dut_u (.core_clk, .rst_b, .cs_b, .ras_b, .cas_b, .we_b, .bank_addr, .addr,
      .termination_control, .self_refresh, .bank_open, .power_down, .column_latency,
      .loop_enable_ff, .loop_reset_ff, .drive_reduced_ff, .dqs_comp_enable_ff,
      .read_strobe_enable_ff, .read_strobe_comp_enable_ff, .data_out_enable_ff,
      .term_code_ff, .term_active_ff, .calib_code_ff, .additive_latency_ff,
      .read_latency_ff, .write_latency_ff, .fast_refresh_ff, .extended_mode_two_ff,
      .extended_mode_three_ff, .int_read_ff, .int_write_ff);
   // 40 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk; // above the slow-clock limit
   end
   // verdict and end of run
   task automatic wrap_up();
      if (miscompares == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // one request through the model; returns after the device took it
   task automatic issue(input logic [1:0] op, input logic [1:0] bank, input logic [15:0] w);
      @(posedge core_clk);
      req_op <= op;
      req_bank <= bank;
      req_word <= w;
      @(posedge core_clk);
      req_op <= 2'h0;
      @(posedge core_clk);
      #1;
   endtask
   // bounded wait for a level, failure ends the run
   task automatic wait_for(input string nm, ref logic sig, input logic val);
      int n;
      for (n = 0; n < 24 && sig !== val; n++) begin
         @(posedge core_clk);
         #1;
      end
      `CHK(nm, val, sig)
      if (sig !== val) wrap_up();
   endtask
   // load the first register and check every setting derived from it
   task automatic load_check(input logic [15:0] w);
      issue(2'h1, BANK_SEL_ONE, w);
      `CHK("loop", ~w[0], loop_enable_ff)
      `CHK("drive", w[1], drive_reduced_ff)
      `CHK("dqs_comp", ~w[10] & ~w[12], dqs_comp_enable_ff)
      `CHK("rstrobe", w[11] & ~w[12], read_strobe_enable_ff)
      `CHK("rstrobe_c", w[11] & ~w[10] & ~w[12], read_strobe_comp_enable_ff)
      `CHK("data_oe", ~w[12], data_out_enable_ff)
      `CHK("term", {w[6], w[2]}, term_code_ff)
      `CHK("calib", w[9:7], calib_code_ff)
      `CHK("al", w[5:3], additive_latency_ff)
      `CHK("rl", {1'b0, w[5:3]} + CL, read_latency_ff)
      `CHK("wl", {1'b0, w[5:3]} + CL - 4'h1, write_latency_ff)
   endtask
   // column command: internal pulse after al clocks, for one cycle
   task automatic col_check(input logic [1:0] op, input int al);
      int n;
      issue(op, 2'h0, 16'h0000);
      for (n = 0; n < 12 && (op == 2'h2 ? int_read_ff : int_write_ff) !== 1'b1; n++) begin
         @(posedge core_clk);
         #1;
      end
      `CHK("col_delay", al, n)
      @(posedge core_clk);
      #1;
      `CHK("col_pulse", 1'b0, op == 2'h2 ? int_read_ff : int_write_ff)
   endtask
   // main sequence; banks stay idle during loads
   initial begin
      {rst_b, req_term, req_sr, bank_open, power_down} = 5'h00;
      {req_op, req_bank, req_word} = 20'h00000;
      column_latency = CL[2:0];
      miscompares = 0;
      check_count = 0;
      repeat (5) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      #1;
      `CHK("rst_loop", 1'b1, loop_enable_ff)
      `CHK("rst_oe", 1'b1, data_out_enable_ff)
      `CHK("rst_two", MODE_RESET, extended_mode_two_ff)
      `CHK("rst_three", MODE_RESET, extended_mode_three_ff)
      foreach (WORDS[i]) load_check(WORDS[i]);
      issue(2'h1, 2'h0, 16'h0100);
      repeat (200) @(posedge core_clk);
      for (int i = 0; i <= AL_MAX; i++) begin
         load_check(16'(i) << ADDITIVE_LATENCY_LSB);
         col_check(2'h2, i);
         col_check(2'h3, i);
      end
      issue(2'h1, BANK_SEL_TWO, 16'h0080);
      `CHK("fast_refresh", 1'b1, fast_refresh_ff)
      `CHK("emr_two", 17'h00080, extended_mode_two_ff)
      issue(2'h1, BANK_SEL_THREE, 16'h1234);
      `CHK("emr_three", 17'h01234, extended_mode_three_ff)
      `CHK("emr_two_kept", 17'h00080, extended_mode_two_ff)
      issue(2'h1, 2'h0, 16'h0001);
      `CHK("base_ignored", 1'b1, loop_enable_ff)
      `CHK("emr_three_kept", 17'h01234, extended_mode_three_ff)
      load_check(16'h0004);
      @(posedge core_clk);
      bank_open <= 1'b1;
      req_term <= 1'b1;
      wait_for("term_on", term_active_ff, 1'b1);
      @(posedge core_clk) bank_open <= 1'b0;
      wait_for("term_idle", term_active_ff, 1'b0);
      @(posedge core_clk) power_down <= 1'b1;
      wait_for("term_pd", term_active_ff, 1'b1);
      load_check(16'h0000);
      wait_for("term_code_off", term_active_ff, 1'b0);
      @(posedge core_clk) req_sr <= 1'b1;
      wait_for("sr_loop_off", loop_enable_ff, 1'b0);
      @(posedge core_clk) req_sr <= 1'b0;
      wait_for("sr_loop_reset", loop_reset_ff, 1'b1);
      `CHK("sr_loop_on", 1'b1, loop_enable_ff)
      @(posedge core_clk);
      #1;
      `CHK("sr_reset_pulse", 1'b0, loop_reset_ff)
      wrap_up();
   end
endmodule // dxm_ext_mode_tb
